/* File: logic/sac_defs.svh */
// Purpose: Named offsets, fields, resets and timing counts for the converter control block
// Assumes: Wishbone byte addresses, one 32-bit word per register
// Notes: Definitions only
`ifndef SAC_DEFS_SVH
`define SAC_DEFS_SVH
`define SAC_ADDR_W 4
`define SAC_OFF_CTRL_MAIN 4'h0
`define SAC_OFF_FMT_REF 4'h4
`define SAC_OFF_RES_HIGH 4'h8
`define SAC_OFF_RES_LOW 4'hC
`define SAC_OFF_FLAGS 4'h1
`define SAC_OFF_FLAGS_W 4'h0
`define SAC_FLAG_ADDR 4'h0
`define SAC_BIT_ENABLE 0
`define SAC_BIT_GO 1
`define SAC_BIT_FORMAT 7
`define SAC_BIT_NEG_REF 5
`define SAC_BIT_POS_REF 4
`define SAC_BIT_DONE 0
`define SAC_BIT_IRQ_EN 1
`define SAC_RESET_BYTE 8'h00
`define SAC_CLK_RC 2'h3
`define SAC_CLK_DIV2 2'h0
`define SAC_CLK_DIV8 2'h1
`define SAC_DIV2_TOP 5'h00
`define SAC_DIV8_TOP 5'h03
`define SAC_DIV32_TOP 5'h0F
`define SAC_CONV_TADS 4'hB
`define SAC_ABORT_TADS 4'h2
`define SAC_RC_EXTRA_CYC 3'h4
`define SAC_RES_W 10
`endif

/* File: logic/sac_pkg.sv */
// Purpose: Types shared by the converter control files
// Assumes: Constants live in sac_defs.svh
// Notes: No imports anywhere; use sac_pkg::name
package sac_pkg;
   typedef enum logic [2:0] {
      SAC_IDLE,
      SAC_PRESTART,
      SAC_CONVERT,
      SAC_RECOVER
   } sac_state_t;
   typedef struct packed {
      logic [3:0] channel;
      logic pos_ext;
      logic neg_ext;
      logic powered;
      logic sample;
   } sac_analog_t;
   typedef struct packed {
      logic [1:0] clk_sel;
      logic [3:0] channel;
      logic go;
      logic enable;
   } sac_ctrl_t;
endpackage

/* File: logic/sac_tick_gen.sv */
// Purpose: Bit-period tick source from prescaler or synchronised RC oscillator
// Assumes: RC oscillator far slower than clk_i
// Notes: One-cycle tick per bit period
`timescale 1ns/10ps
`include "sac_defs.svh"
module sac_tick_gen (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic [1:0] clk_sel_i,
   input wire logic rc_osc_i,
   output logic tick_o
);
   logic [4:0] div_q;
   logic [2:0] rc_sync_q;
   logic [4:0] top;
   logic rc_edge;

   always_comb begin
      case (clk_sel_i)
         `SAC_CLK_DIV2: top = `SAC_DIV2_TOP;
         `SAC_CLK_DIV8: top = `SAC_DIV8_TOP;
         default: top = `SAC_DIV32_TOP;
      endcase
   end

   // Rising edge while second stage is high and third stage is still low
   assign rc_edge = rc_sync_q[1] & ~rc_sync_q[2];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rc_sync_q <= 3'h0;
      end else begin
         rc_sync_q <= {rc_sync_q[1:0], rc_osc_i};
      end
   end

   // Half-period prescaler: bit period is 2*(top+1) clocks
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         div_q <= 5'h00;
         tick_o <= 1'b0;
      end else if (clk_sel_i == `SAC_CLK_RC) begin
         div_q <= 5'h00;
         tick_o <= rc_edge;
      end else begin
         tick_o <= 1'b0;
         if (div_q == {top[3:0], 1'b1}) begin
            div_q <= 5'h00;
            tick_o <= 1'b1;
         end else begin
            div_q <= div_q + 5'h01;
         end
      end
   end
endmodule // sac_tick_gen

/* File: logic/sac_result_fmt.sv */
// Purpose: Places the 10-bit result into high and low bytes
// Assumes: Purely combinational
// Notes: Unused bits read zero
`timescale 1ns/10ps
`include "sac_defs.svh"
module sac_result_fmt (
   input wire logic [`SAC_RES_W-1:0] res_i,
   input wire logic right_i,
   output logic [7:0] high_o,
   output logic [7:0] low_o
);
   always_comb begin
      if (right_i) begin
         high_o = {6'h00, res_i[9:8]};
         low_o = res_i[7:0];
      end else begin
         high_o = res_i[9:2];
         low_o = {res_i[1:0], 6'h00};
      end
   end
endmodule // sac_result_fmt

/* File: logic/sac_conv_ctrl.sv */
// Purpose: Successive-approximation conversion control with Wishbone registers
// Assumes: Analog array returns comparator decision each bit period
// Notes: Offsets 0x0 main control, 0x4 format/ref, 0x8 result high,
// 0xC result low, 0x10 flag/enable
// Function
// - Bit clock: system clock /2, /8, /32, or RC oscillator
// - Each conversion lasts exactly 11 bit periods from start
// - Channel code 0-13 external, 14 comparator reference, 15 fixed reference
// - Writing one to go bit starts; bit reads one while running
// - Completion clears go, sets done flag, loads result together
// - Done flag always set; interrupt only when enable set
// - Completion in sleep with interrupt enabled raises wake request
// - Enable bit powers converter; clear means unpowered
// - Clearing go early abandons conversion, keeps old result
// - After abort wait two bit periods, then restart acquisition; sample_o is already high during the wait
// - Reset returns registers, powers off, ends conversion
// - RC clock source delays start by one instruction cycle
// - Sleep, RC, interrupt disabled: power off after completion, enable reads one
// - Sleep with non-RC clock aborts and powers off, enable stays set
// - Compare trigger sets go and clears companion timer
// - Format bit one right-justified, zero left-justified
// - Left: bits 9-2 high byte, 1-0 in low bits 7-6
// - Right: bits 9-8 in high bits 1-0, 7-0 low byte
// - Bit 5 external negative reference, bit 4 external positive reference
`timescale 1ns/10ps
`include "sac_defs.svh"
module sac_conv_ctrl (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic rc_osc_i,
   input wire logic cmp_bit_i,
   input wire logic sleep_i,
   input wire logic special_trig_i,
   output logic [3:0] channel_o,
   output logic pos_ref_ext_o,
   output logic neg_ref_ext_o,
   output logic analog_power_o,
   output logic sample_o,
   output logic [`SAC_RES_W-1:0] dac_code_o,
   output logic irq_o,
   output logic wake_o,
   output logic timer_clear_o
);
   sac_pkg::sac_ctrl_t ctrl_q;
   logic format_q;
   logic neg_ref_q;
   logic pos_ref_q;
   logic done_q;
   logic irq_en_q;
   logic [7:0] res_high_q;
   logic [7:0] res_low_q;
   sac_pkg::sac_state_t state_q;
   logic [3:0] tad_q;
   logic [2:0] wait_q;
   logic [`SAC_RES_W-1:0] sar_q;
   logic [`SAC_RES_W-1:0] final_code;
   logic off_q;
   logic sleep_q;
   logic [2:0] trig_sync_q;
   logic [2:0] slp_sync_q;
   logic tick;
   logic run;
   logic [7:0] fmt_high;
   logic [7:0] fmt_low;
   logic wb_req;
   logic wr_lane0;
   logic [7:0] wbyte;
   logic wr_main;
   logic wr_fmt;
   logic wr_flag;
   logic go_set_sw;
   logic go_clr_sw;
   logic trig;
   logic finish;
   logic [31:0] rd_data;
   sac_pkg::sac_analog_t ana;

   function automatic logic hit(input logic [4:0] adr, input logic [3:0] off, input logic hi);
      hit = (adr[3:0] == off) && (adr[4] == hi);
   endfunction

   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   // Writes land at the edge where the master samples ack
   assign wr_lane0 = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
   assign wbyte = wb_dat_i[7:0];
   assign wr_main = wr_lane0 & hit(wb_adr_i, `SAC_OFF_CTRL_MAIN, 1'b0);
   assign wr_fmt = wr_lane0 & hit(wb_adr_i, `SAC_OFF_FMT_REF, 1'b0);
   assign wr_flag = wr_lane0 & hit(wb_adr_i, `SAC_FLAG_ADDR, 1'b1);
   assign go_set_sw = wr_main & wbyte[`SAC_BIT_GO] & ~ctrl_q.go;
   assign go_clr_sw = wr_main & ~wbyte[`SAC_BIT_GO] & ctrl_q.go;

   // Second and third stage agree on a high level
   assign trig = trig_sync_q[1] & trig_sync_q[2] & ~sleep_q;
   assign finish = (state_q == sac_pkg::SAC_CONVERT) && tick && (tad_q == `SAC_CONV_TADS - 4'h1);
   assign run = (state_q == sac_pkg::SAC_CONVERT) || (state_q == sac_pkg::SAC_RECOVER);

   sac_tick_gen u_tick (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(run),
      .clk_sel_i(ctrl_q.clk_sel),
      .rc_osc_i(rc_osc_i),
      .tick_o(tick)
   );

   // Last decision is still on the comparator when the result loads
   assign final_code = {sar_q[`SAC_RES_W-1:1], cmp_bit_i};

   sac_result_fmt u_fmt (
      .res_i(final_code),
      .right_i(format_q),
      .high_o(fmt_high),
      .low_o(fmt_low)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trig_sync_q <= 3'h0;
         slp_sync_q <= 3'h0;
         sleep_q <= 1'b0;
      end else begin
         trig_sync_q <= {trig_sync_q[1:0], special_trig_i};
         slp_sync_q <= {slp_sync_q[1:0], sleep_i};
         if (slp_sync_q[1] == slp_sync_q[2]) begin
            sleep_q <= slp_sync_q[2];
         end
      end
   end

   // Main control register; trigger taken as a level while stages two and three are both high
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= sac_pkg::sac_ctrl_t'(`SAC_RESET_BYTE);
      end else begin
         if (wr_main) begin
            ctrl_q <= sac_pkg::sac_ctrl_t'(wbyte);
         end
         if (trig && !ctrl_q.go && ctrl_q.enable) begin
            ctrl_q.go <= 1'b1;
         end else if (finish) begin
            ctrl_q.go <= 1'b0;
         end else if (sleep_q && ctrl_q.clk_sel != `SAC_CLK_RC) begin
            ctrl_q.go <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         format_q <= 1'b0;
         neg_ref_q <= 1'b0;
         pos_ref_q <= 1'b0;
      end else if (wr_fmt) begin
         format_q <= wbyte[`SAC_BIT_FORMAT];
         neg_ref_q <= wbyte[`SAC_BIT_NEG_REF];
         pos_ref_q <= wbyte[`SAC_BIT_POS_REF];
      end
   end

   // Flag register: hardware set wins over a same-cycle clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_q <= 1'b0;
         irq_en_q <= 1'b0;
      end else begin
         if (wr_flag) begin
            irq_en_q <= wbyte[`SAC_BIT_IRQ_EN];
         end
         if (finish) begin
            done_q <= 1'b1;
         end else if (wr_flag) begin
            done_q <= wbyte[`SAC_BIT_DONE];
         end
      end
   end

   // Sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= sac_pkg::SAC_IDLE;
         tad_q <= 4'h0;
         wait_q <= 3'h0;
         sar_q <= {`SAC_RES_W{1'b0}};
      end else begin
         case (state_q)
            sac_pkg::SAC_IDLE: begin
               tad_q <= 4'h0;
               if (ctrl_q.go && ctrl_q.enable && !off_q) begin
                  wait_q <= 3'h0;
                  if (ctrl_q.clk_sel == `SAC_CLK_RC) begin
                     state_q <= sac_pkg::SAC_PRESTART;
                  end else begin
                     state_q <= sac_pkg::SAC_CONVERT;
                  end
                  sar_q <= {1'b1, {(`SAC_RES_W-1){1'b0}}};
               end
            end
            sac_pkg::SAC_PRESTART: begin
               wait_q <= wait_q + 3'h1;
               if (!ctrl_q.go || !ctrl_q.enable) begin
                  state_q <= sac_pkg::SAC_IDLE;
               end else if (wait_q == `SAC_RC_EXTRA_CYC - 3'h1) begin
                  state_q <= sac_pkg::SAC_CONVERT;
               end
            end
            sac_pkg::SAC_CONVERT: begin
               if (!ctrl_q.go || !ctrl_q.enable) begin
                  tad_q <= 4'h0;
                  state_q <= sac_pkg::SAC_RECOVER;
               end else if (tick) begin
                  tad_q <= tad_q + 4'h1;
                  if (tad_q != 4'h0 && tad_q <= 4'hA) begin
                     sar_q[4'hA - tad_q] <= cmp_bit_i;
                     if (tad_q != 4'hA) begin
                        sar_q[4'h9 - tad_q] <= 1'b1;
                     end
                  end
                  if (finish) begin
                     state_q <= sac_pkg::SAC_IDLE;
                  end
               end
            end
            sac_pkg::SAC_RECOVER: begin
               if (tick) begin
                  tad_q <= tad_q + 4'h1;
                  if (tad_q == `SAC_ABORT_TADS - 4'h1) begin
                     state_q <= sac_pkg::SAC_IDLE;
                  end
               end
            end
            default: state_q <= sac_pkg::SAC_IDLE;
         endcase
      end
   end

   // Result registers hold across aborts
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         res_high_q <= `SAC_RESET_BYTE;
         res_low_q <= `SAC_RESET_BYTE;
      end else if (finish) begin
         res_high_q <= fmt_high;
         res_low_q <= fmt_low;
      end
   end

   // Sleep power-down latch, released when sleep ends or enable is cleared
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         off_q <= 1'b0;
      end else if (!sleep_q || !ctrl_q.enable) begin
         off_q <= 1'b0;
      end else if (ctrl_q.clk_sel != `SAC_CLK_RC) begin
         off_q <= 1'b1;
      end else if (finish && !irq_en_q) begin
         off_q <= 1'b1;
      end
   end

   always_comb begin
      ana.channel = ctrl_q.channel;
      ana.pos_ext = pos_ref_q;
      ana.neg_ext = neg_ref_q;
      ana.powered = ctrl_q.enable & ~off_q;
      ana.sample = ctrl_q.enable & ~off_q & (state_q != sac_pkg::SAC_CONVERT);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         channel_o <= 4'h0;
         pos_ref_ext_o <= 1'b0;
         neg_ref_ext_o <= 1'b0;
         analog_power_o <= 1'b0;
         sample_o <= 1'b0;
         dac_code_o <= {`SAC_RES_W{1'b0}};
         irq_o <= 1'b0;
         wake_o <= 1'b0;
         timer_clear_o <= 1'b0;
      end else begin
         channel_o <= ana.channel;
         pos_ref_ext_o <= ana.pos_ext;
         neg_ref_ext_o <= ana.neg_ext;
         analog_power_o <= ana.powered;
         sample_o <= ana.sample;
         dac_code_o <= sar_q;
         irq_o <= done_q & irq_en_q;
         wake_o <= finish & sleep_q & irq_en_q;
         timer_clear_o <= trig & ~ctrl_q.go & ctrl_q.enable;
      end
   end

   always_comb begin
      rd_data = 32'h0000_0000;
      if (hit(wb_adr_i, `SAC_OFF_CTRL_MAIN, 1'b0)) begin
         rd_data[7:0] = ctrl_q;
      end else if (hit(wb_adr_i, `SAC_OFF_FMT_REF, 1'b0)) begin
         rd_data[`SAC_BIT_FORMAT] = format_q;
         rd_data[`SAC_BIT_NEG_REF] = neg_ref_q;
         rd_data[`SAC_BIT_POS_REF] = pos_ref_q;
      end else if (hit(wb_adr_i, `SAC_OFF_RES_HIGH, 1'b0)) begin
         rd_data[7:0] = res_high_q;
      end else if (hit(wb_adr_i, `SAC_OFF_RES_LOW, 1'b0)) begin
         rd_data[7:0] = res_low_q;
      end else if (hit(wb_adr_i, `SAC_FLAG_ADDR, 1'b1)) begin
         rd_data[`SAC_BIT_DONE] = done_q;
         rd_data[`SAC_BIT_IRQ_EN] = irq_en_q;
      end
   end

   // One wait state: ack one edge after request; unmapped reads zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req && !wb_we_i) begin
            wb_dat_o <= rd_data;
         end
      end
   end
endmodule // sac_conv_ctrl

/* File: verif/sac_analog_model.sv */
// Purpose: Comparator side of the analog array for the converter bench
// Assumes: Trial code settles within one clock
// Notes: Unpowered array gives a toggling decision, never a held one
`timescale 1ns/10ps
module sac_analog_model (
   input wire logic clk_i,
   input wire logic power_i,
   input wire logic [9:0] code_i,
   input wire logic [9:0] level_i,
   output logic cmp_o
);
   logic junk_q = 1'b0;
   always_ff @(posedge clk_i) begin
      junk_q <= ~junk_q;
   end
   assign cmp_o = power_i ? (level_i >= code_i) : junk_q;
endmodule // sac_analog_model

/* File: verif/sac_conv_ctrl_assertions.sv */
// Purpose: Port checks for the converter control block
// Assumes: Ack one cycle after the taking edge
// Notes: Helper flops mirror the written fields
`timescale 1ns/10ps
module sac_conv_ctrl_assertions (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic sleep_i,
   input wire logic special_trig_i,
   input wire logic [3:0] channel_o,
   input wire logic pos_ref_ext_o,
   input wire logic neg_ref_ext_o,
   input wire logic analog_power_o,
   input wire logic irq_o,
   input wire logic wake_o,
   input wire logic timer_clear_o
);
   logic wr;
   logic en_q;
   logic ien_q;
   logic [3:0] ch_q;
   logic [1:0] ref_q;
   logic [3:0] age_q;
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_q <= 1'b0;
         ien_q <= 1'b0;
         ch_q <= 4'h0;
         ref_q <= 2'h0;
      end else if (wr && wb_adr_i == 5'h00) begin
         en_q <= wb_dat_i[0];
         ch_q <= wb_dat_i[5:2];
      end else if (wr && wb_adr_i == 5'h04) begin
         ref_q <= wb_dat_i[5:4];
      end else if (wr && wb_adr_i == 5'h10) begin
         ien_q <= wb_dat_i[1];
      end
   end
   // Trigger passes a 3-flop synchroniser, so allow a few cycles of age
   always_ff @(posedge clk_i) begin
      if (rst_i || special_trig_i) begin
         age_q <= 4'h0;
      end else if (age_q != 4'hF) begin
         age_q <= age_q + 4'h1;
      end
   end
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   property p_ack_next;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack late");
   property p_ack_once;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack too long");
   property p_reset_off;
      disable iff (1'b0) rst_i |=> !analog_power_o && !irq_o && !wake_o;
   endproperty
   a_reset_off: assert property (p_reset_off) else $error("reset not quiet");
   property p_ref;
      wr && wb_adr_i == 5'h04 |-> ##3 {neg_ref_ext_o, pos_ref_ext_o} == ref_q;
   endproperty
   a_ref: assert property (p_ref) else $error("reference selects wrong");
   property p_chan;
      wr && wb_adr_i == 5'h00 |-> ##3 channel_o == ch_q;
   endproperty
   a_chan: assert property (p_chan) else $error("channel wrong");
   property p_irq;
      irq_o |-> ien_q || $past(ien_q) || $past(ien_q, 2);
   endproperty
   a_irq: assert property (p_irq) else $error("irq while disabled");
   property p_wake;
      wake_o |-> ien_q && $past(sleep_i, 4) ##1 !wake_o;
   endproperty
   a_wake: assert property (p_wake) else $error("bad wake pulse");
   property p_power;
      analog_power_o |-> en_q || $past(en_q) || $past(en_q, 2);
   endproperty
   a_power: assert property (p_power) else $error("power without enable");
   property p_tclr;
      timer_clear_o |-> age_q < 4'h8;
   endproperty
   a_tclr: assert property (p_tclr) else $error("timer clear untriggered");
   c_wake: cover property (wake_o);
   c_tclr: cover property (timer_clear_o);
   c_irq: cover property ($rose(irq_o));
endmodule // sac_conv_ctrl_assertions
bind sac_conv_ctrl sac_conv_ctrl_assertions u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_ack_o(wb_ack_o), .sleep_i(sleep_i), .special_trig_i(special_trig_i),
   .channel_o(channel_o), .pos_ref_ext_o(pos_ref_ext_o), .neg_ref_ext_o(neg_ref_ext_o),
   .analog_power_o(analog_power_o), .irq_o(irq_o), .wake_o(wake_o),
   .timer_clear_o(timer_clear_o)
);

/* File: verif/tb_sac_conv_ctrl.sv */
// Purpose: Self-checking bench for the converter control block
// Assumes: Read data arrives with ack one cycle after the taking edge
// Notes: Reads queue their expected word; a monitor compares on ack
`timescale 1ns/10ps
module tb_sac_conv_ctrl;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [4:0] adr = 5'h00;
   logic [31:0] dw = 32'h00000000;
   logic rc = 1'b0;
   logic slp = 1'b0;
   logic trig = 1'b0;
   logic [9:0] vin = 10'h000;
   logic [9:0] old = 10'h000;
   logic [31:0] seed = 32'hE38C7C5F;
   logic fmt = 1'b0;
   logic ien = 1'b0;
   logic [31:0] dr;
   logic [3:0] ch;
   logic [9:0] dac;
   logic ack, cmp, pref, nref, pwr, smp, irq, wake, tclr;
   logic [31:0] expq[$];
   int n_fail = 0;
   int comparisons = 0;
   int ncyc = 0;
   int wakes = 0;
   int clears = 0;
   always #2.5 clk = ~clk;
   // RC source far slower than the system clock: 40 clocks a period
   always #100 rc = ~rc;
   sac_conv_ctrl uut (
      .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
      .rc_osc_i(rc), .cmp_bit_i(cmp), .sleep_i(slp), .special_trig_i(trig),
      .channel_o(ch), .pos_ref_ext_o(pref), .neg_ref_ext_o(nref), .analog_power_o(pwr),
      .sample_o(smp), .dac_code_o(dac), .irq_o(irq), .wake_o(wake), .timer_clear_o(tclr)
   );
   sac_analog_model u_analog (.clk_i(clk), .power_i(pwr), .code_i(dac), .level_i(vin),
      .cmp_o(cmp));
   function automatic logic [9:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[9:0];
   endfunction
   function automatic logic [31:0] res_hi(input logic [9:0] v);
      return fmt ? {30'h0, v[9:8]} : {24'h0, v[9:2]};
   endfunction
   function automatic logic [31:0] res_lo(input logic [9:0] v);
      return fmt ? {24'h0, v[7:0]} : {24'h0, v[1:0], 6'h00};
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d,
      input logic [31:0] e);
      int n;
      n = 0;
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      dw <= {24'h000000, d};
      if (!w)
         expq.push_back(e);
      @(posedge clk);
      while (ack !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      if (n == 20)
         n_fail++;
      cyc <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask
   task automatic conv(input logic [1:0] cs, input logic [3:0] c, input logic s);
      int div;
      div = (cs == 2'h3) ? 40 : (2 << (2 * cs));
      vin <= rnd();
      wb(1'b1, 5'h10, {6'h00, ien, 1'b0}, 32'h0);
      wb(1'b1, 5'h04, {fmt, 7'h00}, 32'h0);
      wb(1'b1, 5'h00, {cs, c, 2'b01}, 32'h0);
      repeat (20) @(posedge clk);
      check({28'h0, ch}, {28'h0, c});
      wb(1'b1, 5'h00, {cs, c, 2'b11}, 32'h0);
      if (s)
         slp <= 1'b1;
      repeat ((cs == 2'h3) ? 396 : 11 * div - 4) @(posedge clk);
      wb(1'b0, 5'h00, 8'h00, {24'h0, cs, c, 2'b11});
      repeat ((cs == 2'h3) ? 61 : 5) @(posedge clk);
      wb(1'b0, 5'h00, 8'h00, {24'h0, cs, c, 2'b01});
      wb(1'b0, 5'h08, 8'h00, res_hi(vin));
      wb(1'b0, 5'h0C, 8'h00, res_lo(vin));
      wb(1'b0, 5'h10, 8'h00, {30'h0, ien, 1'b1});
      check({31'h0, irq}, {31'h0, ien});
      check({31'h0, pwr}, {31'h0, !s || ien});
      wb(1'b1, 5'h10, {6'h00, ien, 1'b0}, 32'h0);
      slp <= 1'b0;
      old = vin;
      repeat (3) @(posedge clk);
      check({31'h0, irq}, 32'h0);
   endtask
   always @(posedge clk)
      if (ack === 1'b1 && cyc && !we && expq.size() > 0)
         check(dr, expq.pop_front());
   always @(posedge clk) begin
      ncyc++;
      wakes += int'(wake === 1'b1);
      clears += int'(tclr === 1'b1);
      if (ncyc == 20000) begin
         n_fail++;
         test_done();
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      wb(1'b0, 5'h00, 8'h00, 32'h0);
      wb(1'b0, 5'h10, 8'h00, 32'h0);
      wb(1'b1, 5'h14, 8'hFF, 32'h0);
      wb(1'b0, 5'h14, 8'h00, 32'h0);
      wb(1'b1, 5'h04, 8'hB0, 32'h0);
      wb(1'b0, 5'h04, 8'h00, 32'h000000B0);
      check({30'h0, nref, pref}, 32'h3);
      wb(1'b1, 5'h04, 8'h10, 32'h0);
      @(posedge clk);
      check({30'h0, nref, pref}, 32'h1);
      $display("test registers done");
      for (int i = 0; i < 4; i++) begin
         fmt = i[0];
         ien = i[1];
         conv(i[1:0], 4'hC + i[3:0], 1'b0);
      end
      $display("test conversions done");
      conv(2'h3, 4'h2, 1'b1);
      check(wakes, 32'h1);
      ien = 1'b0;
      conv(2'h3, 4'h5, 1'b1);
      check(wakes, 32'h1);
      $display("test sleep done");
      vin <= rnd();
      wb(1'b1, 5'h00, 8'h47, 32'h0);
      repeat (30) @(posedge clk);
      check({31'h0, smp}, 32'h0);
      wb(1'b1, 5'h00, 8'h45, 32'h0);
      wb(1'b0, 5'h00, 8'h00, 32'h00000045);
      wb(1'b0, 5'h08, 8'h00, res_hi(old));
      wb(1'b0, 5'h0C, 8'h00, res_lo(old));
      repeat (26) @(posedge clk);
      check({31'h0, smp}, 32'h1);
      wb(1'b1, 5'h00, 8'hB7, 32'h0);
      repeat (20) @(posedge clk);
      slp <= 1'b1;
      repeat (12) @(posedge clk);
      check({31'h0, pwr}, 32'h0);
      wb(1'b0, 5'h00, 8'h00, 32'h000000B5);
      slp <= 1'b0;
      $display("test abort done");
      wb(1'b1, 5'h00, 8'h05, 32'h0);
      vin <= rnd();
      repeat (20) @(posedge clk);
      trig <= 1'b1;
      repeat (8) @(posedge clk);
      trig <= 1'b0;
      check({31'h0, clears > 0}, 32'h1);
      wb(1'b0, 5'h00, 8'h00, 32'h00000007);
      repeat (40) @(posedge clk);
      wb(1'b0, 5'h0C, 8'h00, res_lo(vin));
      wb(1'b1, 5'h00, 8'h07, 32'h0);
      repeat (6) @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check({31'h0, pwr}, 32'h0);
      wb(1'b0, 5'h00, 8'h00, 32'h0);
      $display("test trigger and reset done");
      test_done();
   end
endmodule // tb_sac_conv_ctrl
